// file: rtl/rfcmd_pkg.sv
package rfcmd_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [4:0] ADDR_CHIP      = 5'h00;
	localparam logic [4:0] ADDR_PROTO     = 5'h01;
	localparam logic [4:0] ADDR_OPT_FIRST = 5'h02;
	localparam logic [4:0] ADDR_TMR_HI    = 5'h04;
	localparam logic [4:0] ADDR_TMR_LO    = 5'h05;
	localparam logic [4:0] ADDR_RX_WAIT   = 5'h08;
	localparam logic [4:0] ADDR_MOD_CLK   = 5'h09;
	localparam logic [4:0] ADDR_OPT_LAST  = 5'h0B;
	localparam logic [4:0] ADDR_IRQ       = 5'h0C;
	localparam logic [4:0] ADDR_MASK      = 5'h0D;
	localparam logic [4:0] ADDR_COLL      = 5'h0E;
	localparam logic [4:0] ADDR_RSSI      = 5'h0F;
	localparam logic [4:0] ADDR_SPEC1     = 5'h10;
	localparam logic [4:0] ADDR_SPEC2     = 5'h11;
	localparam logic [4:0] ADDR_FIFO_LVL  = 5'h14;
	localparam logic [4:0] ADDR_TEST1     = 5'h1A;
	localparam logic [4:0] ADDR_TEST2     = 5'h1B;
	localparam logic [4:0] ADDR_FIFO_STAT = 5'h1C;
	localparam logic [4:0] ADDR_TX_LEN1   = 5'h1D;
	localparam logic [4:0] ADDR_TX_LEN2   = 5'h1E;
	localparam logic [4:0] ADDR_FIFO_DATA = 5'h1F;

	// ****************************************
	// Direct command codes and host byte fields
	// ****************************************
	localparam logic [4:0] CMD_IDLE      = 5'h00;
	localparam logic [4:0] CMD_SW_INIT   = 5'h03;
	localparam logic [4:0] CMD_FIFO_RST  = 5'h0F;
	localparam logic [4:0] CMD_TX_NOCRC  = 5'h10;
	localparam logic [4:0] CMD_TX_CRC    = 5'h11;
	localparam logic [4:0] CMD_DTX_NOCRC = 5'h12;
	localparam logic [4:0] CMD_DTX_CRC   = 5'h13;
	localparam logic [4:0] CMD_NEXT_SLOT = 5'h14;
	localparam logic [4:0] CMD_RX_BLOCK  = 5'h16;
	localparam logic [4:0] CMD_RX_ENABLE = 5'h17;
	localparam logic [4:0] CMD_RF_INT    = 5'h18;
	localparam logic [4:0] CMD_RF_EXT    = 5'h19;
	localparam int HB_CMD  = 7;
	localparam int HB_READ = 6;
	localparam int HB_CONT = 5;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int CLO_LO_BIT   = 4;
	localparam int CLO_HI_BIT   = 5;
	localparam int IRQ_TX_END   = 7;
	localparam int RSSI_OSC_BIT = 6;
	localparam int FSTAT_OVF    = 7;
	localparam logic [7:0] PROTO_VIC_MASK = 8'h18;
	localparam logic [7:0] CHIP_RST  = 8'h01;
	localparam logic [7:0] PROTO_RST = 8'h02;
	localparam logic [7:0] MASK_RST  = 8'h3E;
	localparam logic [7:0] RSSI_RST  = 8'h40;
	localparam logic [0:9][7:0] OPT_PRESET = {8'h00, 8'h00, 8'hC1, 8'hC1, 8'h00,
		8'h0E, 8'h07, 8'h91, 8'h10, 8'h87};

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int TX_TICK_NS    = 1000;
	localparam int TX_TICK_CYC   = TX_TICK_NS / CLK_PERIOD_NS;
	localparam int RXW_TICK_NS   = 9440;
	localparam int RXW_TICK_CYC  = RXW_TICK_NS / CLK_PERIOD_NS;
	localparam logic [3:0] IDLE_CYC_SERIAL   = 4'h8;
	localparam logic [3:0] IDLE_CYC_PARALLEL = 4'h1;

	// ****************************************
	// Synchroniser bit positions
	// ****************************************
	localparam int P_MAIN   = 8;
	localparam int P_AUX    = 11;
	localparam int P_OSC    = 14;
	localparam int P_SERIAL = 15;
	localparam int P_STB    = 16;
	localparam int P_SEL    = 17;
	localparam int P_EN     = 18;
	localparam int PIN_W    = 19;

	typedef enum logic [2:0] {HP_ADDR = 3'b001, HP_WDATA = 3'b010, HP_RDATA = 3'b100} rfcmd_hp_t;
	typedef enum logic [3:0] {TX_IDLE = 4'b0001, TX_ARMED = 4'b0010, TX_TIMER = 4'b0100,
		TX_SEND = 4'b1000} rfcmd_tx_t;

endpackage

// file: rtl/rfcmd_core.sv
`timescale 1ns/1ps
// Behaviour
// - FIFO reset clears FIFO, status, collision position
// - Immediate transmit starts on first FIFO byte
// - 0x11 appends CRC, 0x10 sends none
// - Delayed transmit waits for transmit timer
// - Next slot marker, vicinity protocol only
// - Block receiver holds decoder in reset
// - Enable receiver releases block-command reset only
// - Transmit end releases decoder reset automatically
// - Nonzero wait time delays decoder release
// - Internal test stores both 3-bit levels
// - External test stores main 3-bit level
// - Start in vicinity protocol after enable
// - Protocol write presets option registers
// - Option edits persist until protocol reselected
// - Clock divider bits survive protocol select
// - Status registers read-only, unused addresses read zero, others read-write
// - Bit 7 set means direct command
// - Idle gives eight or one dummy cycles
// - Software init equals power-on reset
module rfcmd_core #(
	parameter int FIFO_DEPTH = 127
) (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       en_pin,
	input  wire logic       hp_sel,
	input  wire logic       hp_strobe,
	input  wire logic [7:0] hp_din,
	output logic [7:0]      hp_dout,
	output logic            hp_dout_oe,
	input  wire logic       port_is_serial,
	input  wire logic [2:0] rssi_main_code,
	input  wire logic [2:0] rssi_aux_code,
	input  wire logic       osc_stable,
	output logic [7:0]      tx_byte,
	output logic            tx_byte_valid,
	input  wire logic       tx_byte_ready,
	output logic            tx_frame_active,
	output logic            tx_append_crc,
	output logic            next_slot_pulse,
	input  wire logic [7:0] rx_byte,
	input  wire logic       rx_byte_valid,
	input  wire logic       coll_valid,
	input  wire logic [7:0] coll_pos,
	output logic            rx_decoder_reset,
	output logic            dummy_clk_active,
	output logic            clock_out_div_sel_lo,
	output logic            clock_out_div_sel_hi
);
	import rfcmd_pkg::*;

	if (FIFO_DEPTH < 2 || FIFO_DEPTH > 127) begin
		$error("FIFO_DEPTH must lie in 2..127");
	end

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [PIN_W-1:0]            pin_s1;
		logic [PIN_W-1:0]            pin_s2;
		logic                        strobe_d;
		rfcmd_hp_t                   hp;
		logic [4:0]                  hp_addr;
		logic                        hp_cont;
		logic [7:0]                  dout;
		logic                        dout_oe;
		logic [31:0][7:0]            regs;
		logic [FIFO_DEPTH-1:0][7:0]  mem;
		logic [6:0]                  wr_ptr;
		logic [6:0]                  rd_ptr;
		logic [6:0]                  count;
		logic                        fifo_ovf;
		rfcmd_tx_t                   tx;
		logic                        tx_crc;
		logic [11:0]                 tx_sent;
		logic [15:0]                 tick;
		logic [13:0]                 tmr;
		logic [7:0]                  tx_data;
		logic                        tx_valid;
		logic                        rx_block;
		logic [7:0]                  rxw_units;
		logic [15:0]                 rxw_tick;
		logic                        slot_pulse;
		logic [3:0]                  dummy_cnt;
	} rfcmd_state_t;

	function automatic rfcmd_state_t init_state();
		rfcmd_state_t r;
		r = '0;
		r.hp = HP_ADDR;
		r.tx = TX_IDLE;
		r.regs[ADDR_CHIP] = CHIP_RST;
		r.regs[ADDR_PROTO] = PROTO_RST;
		for (int i = 0; i < 10; i++) begin
			r.regs[int'(ADDR_OPT_FIRST) + i] = OPT_PRESET[i];
		end
		r.regs[ADDR_MASK] = MASK_RST;
		r.regs[ADDR_RSSI] = RSSI_RST;
		return r;
	endfunction

	localparam rfcmd_state_t ST_RST = init_state();

	function automatic logic is_rw(input logic [4:0] a);
		return (a <= ADDR_OPT_LAST) || a == ADDR_MASK || a == ADDR_SPEC1 || a == ADDR_SPEC2 ||
			a == ADDR_FIFO_LVL || a == ADDR_TEST1 || a == ADDR_TEST2 || a == ADDR_TX_LEN1 ||
			a == ADDR_TX_LEN2;
	endfunction

	rfcmd_state_t s_reg;
	rfcmd_state_t s_next;
	logic         cmd_fire;
	logic [4:0]   cmd_code;
	logic         proto_wr;
	logic         tx_end;
	logic         do_init;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic        stb;
		logic [7:0]  din;
		logic        push;
		logic [7:0]  push_data;
		logic        pop;
		logic [11:0] tx_len;
		logic [4:0]  rd_addr;
		logic        rd_load;
		rfcmd_state_t keep;
		stb = 1'b0;
		din = '0;
		push = 1'b0;
		push_data = '0;
		pop = 1'b0;
		tx_len = '0;
		rd_addr = '0;
		rd_load = 1'b0;
		keep = ST_RST;
		s_next = s_reg;
		cmd_fire = 1'b0;
		cmd_code = '0;
		proto_wr = 1'b0;
		tx_end = 1'b0;
		do_init = 1'b0;
		s_next.pin_s1 = {en_pin, hp_sel, hp_strobe, port_is_serial, osc_stable, rssi_aux_code,
			rssi_main_code, hp_din};
		s_next.pin_s2 = s_reg.pin_s1;
		s_next.strobe_d = s_reg.pin_s2[P_STB];
		s_next.slot_pulse = 1'b0;
		stb = s_reg.pin_s2[P_STB] & ~s_reg.strobe_d;
		din = s_reg.pin_s2[7:0];
		tx_len = {s_reg.regs[ADDR_TX_LEN1], s_reg.regs[ADDR_TX_LEN2][7:4]};
		s_next.regs[ADDR_RSSI][RSSI_OSC_BIT] = s_reg.pin_s2[P_OSC];
		if (s_reg.dummy_cnt != '0) s_next.dummy_cnt = s_reg.dummy_cnt - 4'h1;
		if (s_reg.tx_valid && tx_byte_ready) begin
			s_next.tx_valid = 1'b0;
			s_next.tx_sent = s_reg.tx_sent + 12'h001;
		end

		// Host port
		if (!s_reg.pin_s2[P_SEL]) begin
			s_next.hp = HP_ADDR;
			s_next.dout_oe = 1'b0;
		end else if (stb) begin
			case (s_reg.hp)
				HP_ADDR: begin
					if (din[HB_CMD]) begin
						cmd_fire = (din[HB_READ:HB_CONT] == 2'b00);
						cmd_code = din[4:0];
					end else begin
						s_next.hp_addr = din[4:0];
						s_next.hp_cont = din[HB_CONT];
						if (din[HB_READ]) begin
							s_next.hp = HP_RDATA;
							rd_addr = din[4:0];
							rd_load = 1'b1;
						end else begin
							s_next.hp = HP_WDATA;
						end
					end
				end
				HP_WDATA: begin
					if (s_reg.hp_addr == ADDR_FIFO_DATA) begin
						push = 1'b1;
						push_data = din;
					end else if (s_reg.hp_addr == ADDR_PROTO) begin
						proto_wr = 1'b1;
						s_next.regs[ADDR_PROTO] = din;
					end else if (is_rw(s_reg.hp_addr)) begin
						s_next.regs[s_reg.hp_addr] = din;
					end
					s_next.hp_addr = s_reg.hp_addr + 5'h01;
					if (!s_reg.hp_cont) s_next.hp = HP_ADDR;
				end
				HP_RDATA: begin
					if (s_reg.hp_cont) begin
						s_next.hp_addr = s_reg.hp_addr + 5'h01;
						rd_addr = s_reg.hp_addr + 5'h01;
						rd_load = 1'b1;
					end else begin
						s_next.hp = HP_ADDR;
						s_next.dout_oe = 1'b0;
					end
				end
				default: s_next.hp = HP_ADDR;
			endcase
		end

		// Register read, FIFO read pops, interrupt status clears on read
		if (rd_load) begin
			s_next.dout_oe = 1'b1;
			case (rd_addr)
				ADDR_FIFO_DATA: begin
					s_next.dout = s_reg.mem[s_reg.rd_ptr];
					pop = (s_reg.count != '0);
				end
				ADDR_FIFO_STAT: s_next.dout = {s_reg.fifo_ovf, s_reg.count};
				ADDR_IRQ: begin
					s_next.dout = s_reg.regs[ADDR_IRQ];
					s_next.regs[ADDR_IRQ] = '0;
				end
				ADDR_COLL, ADDR_RSSI: s_next.dout = s_reg.regs[rd_addr];
				default: s_next.dout = is_rw(rd_addr) ? s_reg.regs[rd_addr] : 8'h00;
			endcase
		end

		// Protocol preset keeps only the clock divider select bits
		if (proto_wr) begin
			for (int i = 0; i < 10; i++) begin
				s_next.regs[int'(ADDR_OPT_FIRST) + i] = OPT_PRESET[i];
			end
			s_next.regs[ADDR_MOD_CLK][CLO_HI_BIT:CLO_LO_BIT] =
				s_reg.regs[ADDR_MOD_CLK][CLO_HI_BIT:CLO_LO_BIT];
		end

		// Direct commands
		if (cmd_fire) begin
			case (cmd_code)
				CMD_IDLE: s_next.dummy_cnt = s_reg.pin_s2[P_SERIAL] ? IDLE_CYC_SERIAL : IDLE_CYC_PARALLEL;
				CMD_SW_INIT: do_init = 1'b1;
				CMD_FIFO_RST: begin
					s_next.wr_ptr = '0;
					s_next.rd_ptr = '0;
					s_next.count = '0;
					s_next.fifo_ovf = 1'b0;
					s_next.regs[ADDR_COLL] = '0;
				end
				CMD_TX_NOCRC, CMD_TX_CRC, CMD_DTX_NOCRC, CMD_DTX_CRC: begin
					s_next.tx = cmd_code[1] ? TX_TIMER : TX_ARMED;
					s_next.tx_crc = cmd_code[0];
					s_next.tx_sent = '0;
					s_next.tick = '0;
					s_next.tmr = {s_reg.regs[ADDR_TMR_HI][5:0], s_reg.regs[ADDR_TMR_LO]};
				end
				CMD_NEXT_SLOT: s_next.slot_pulse = ((s_reg.regs[ADDR_PROTO] & PROTO_VIC_MASK) == 8'h00);
				CMD_RX_BLOCK: s_next.rx_block = 1'b1;
				CMD_RX_ENABLE: s_next.rx_block = 1'b0;
				CMD_RF_INT: s_next.regs[ADDR_RSSI][5:0] = s_reg.pin_s2[P_AUX+2:P_MAIN];
				CMD_RF_EXT: s_next.regs[ADDR_RSSI][2:0] = s_reg.pin_s2[P_MAIN+2:P_MAIN];
				default: ;
			endcase
		end

		// Collision capture wins over a FIFO reset in the same cycle
		if (coll_valid) s_next.regs[ADDR_COLL] = coll_pos;

		// Transmit sequencing; the host is trusted to load length before payload
		case (s_reg.tx)
			TX_ARMED: if (s_reg.count != '0) s_next.tx = TX_SEND;
			TX_TIMER: begin
				if (s_reg.tmr != '0) begin
					s_next.tick = (s_reg.tick == 16'(TX_TICK_CYC - 1)) ? 16'h0000 : s_reg.tick + 16'h0001;
					if (s_reg.tick == 16'(TX_TICK_CYC - 1)) s_next.tmr = s_reg.tmr - 14'h0001;
				end else if (s_reg.count != '0) begin
					s_next.tx = TX_SEND;
				end
			end
			TX_SEND: begin
				if (!s_reg.tx_valid && s_reg.tx_sent == tx_len) begin
					tx_end = 1'b1;
					s_next.tx = TX_IDLE;
					s_next.rx_block = 1'b0;
					s_next.rxw_units = s_reg.regs[ADDR_RX_WAIT];
					s_next.rxw_tick = '0;
					s_next.regs[ADDR_IRQ][IRQ_TX_END] = 1'b1;
				end else if (!s_reg.tx_valid && s_reg.count != '0) begin
					s_next.tx_data = s_reg.mem[s_reg.rd_ptr];
					s_next.tx_valid = 1'b1;
					pop = 1'b1;
				end
			end
			default: ;
		endcase

		// Receive wait countdown after transmit
		if (s_reg.rxw_units != '0 && !tx_end) begin
			s_next.rxw_tick = (s_reg.rxw_tick == 16'(RXW_TICK_CYC - 1)) ? 16'h0000 : s_reg.rxw_tick + 16'h0001;
			if (s_reg.rxw_tick == 16'(RXW_TICK_CYC - 1)) s_next.rxw_units = s_reg.rxw_units - 8'h01;
		end

		// FIFO; host writes take the slot, a coincident receive byte is dropped
		if (!push && rx_byte_valid) begin
			push = 1'b1;
			push_data = rx_byte;
		end
		if (push && s_reg.count == 7'(FIFO_DEPTH)) begin
			push = 1'b0;
			s_next.fifo_ovf = 1'b1;
		end
		if (cmd_fire && cmd_code == CMD_FIFO_RST) begin
			pop = 1'b0;
			push = 1'b0;
		end
		if (push) begin
			s_next.mem[s_reg.wr_ptr] = push_data;
			s_next.wr_ptr = (s_reg.wr_ptr == 7'(FIFO_DEPTH - 1)) ? 7'h00 : s_reg.wr_ptr + 7'h01;
		end
		if (pop) s_next.rd_ptr = (s_reg.rd_ptr == 7'(FIFO_DEPTH - 1)) ? 7'h00 : s_reg.rd_ptr + 7'h01;
		if (push && !pop) s_next.count = s_reg.count + 7'h01;
		else if (pop && !push) s_next.count = s_reg.count - 7'h01;

		// Enable pin low or software init presets everything but the synchronisers
		if (!s_reg.pin_s2[P_EN] || do_init) begin
			keep.pin_s1 = s_next.pin_s1;
			keep.pin_s2 = s_next.pin_s2;
			keep.strobe_d = s_next.strobe_d;
			s_next = keep;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_reg <= ST_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign hp_dout              = s_reg.dout;
	assign hp_dout_oe           = s_reg.dout_oe;
	assign tx_byte              = s_reg.tx_data;
	assign tx_byte_valid        = s_reg.tx_valid;
	assign tx_frame_active      = (s_reg.tx == TX_SEND);
	assign tx_append_crc        = s_reg.tx_crc;
	assign next_slot_pulse      = s_reg.slot_pulse;
	assign rx_decoder_reset     = s_reg.rx_block | (s_reg.rxw_units != '0);
	assign dummy_clk_active     = (s_reg.dummy_cnt != '0);
	assign clock_out_div_sel_lo = s_reg.regs[ADDR_MOD_CLK][CLO_LO_BIT];
	assign clock_out_div_sel_hi = s_reg.regs[ADDR_MOD_CLK][CLO_HI_BIT];

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_fifo_rst_clear: assert property (cmd_fire && cmd_code == CMD_FIFO_RST && !coll_valid
		|=> s_reg.count == '0 && s_reg.regs[ADDR_COLL] == 8'h00) else $error("FIFO reset incomplete");
	a_imm_tx_start: assert property (s_reg.tx == TX_ARMED && s_reg.count != '0 && !do_init
		&& s_reg.pin_s2[P_EN] |=> tx_frame_active) else $error("Immediate transmit did not start");
	a_crc_select: assert property (cmd_fire && cmd_code[4:2] == 3'b100 && !do_init && s_reg.pin_s2[P_EN]
		|=> tx_append_crc == $past(cmd_code[0])) else $error("CRC choice wrong");
	a_delay_holds: assert property (s_reg.tx == TX_TIMER && s_reg.tmr != '0
		|=> !tx_frame_active) else $error("Delayed transmit started early");
	a_slot_vic_only: assert property (next_slot_pulse
		|-> $past((s_reg.regs[ADDR_PROTO] & PROTO_VIC_MASK) == 8'h00)) else $error("Slot marker off protocol");
	a_block_rx: assert property (cmd_fire && cmd_code == CMD_RX_BLOCK && s_reg.pin_s2[P_EN]
		|=> rx_decoder_reset) else $error("Receiver not blocked");
	a_tx_end_release: assert property (tx_end && s_reg.pin_s2[P_EN] && !cmd_fire
		|=> rx_decoder_reset == ($past(s_reg.regs[ADDR_RX_WAIT]) != 8'h00)) else $error("Release after transmit wrong");
	a_rssi_int: assert property (cmd_fire && cmd_code == CMD_RF_INT && s_reg.pin_s2[P_EN]
		|=> s_reg.regs[ADDR_RSSI][5:0] == $past(s_reg.pin_s2[P_AUX+2:P_MAIN])) else $error("RSSI not stored");
	a_clo_kept: assert property (proto_wr && s_reg.pin_s2[P_EN]
		|=> $stable({clock_out_div_sel_hi, clock_out_div_sel_lo})) else $error("Divider bits lost");
	a_idle_dummy: assert property (cmd_fire && cmd_code == CMD_IDLE && !s_reg.pin_s2[P_SERIAL] && s_reg.pin_s2[P_EN]
		|=> dummy_clk_active ##1 !dummy_clk_active) else $error("Parallel idle length wrong");

	c_imm_tx: cover property (s_reg.tx == TX_ARMED ##[1:200] tx_end);
	c_delayed_tx: cover property (s_reg.tx == TX_TIMER ##[1:1000] tx_frame_active);
	c_block_enable: cover property (cmd_fire && cmd_code == CMD_RX_BLOCK ##[1:200]
		cmd_fire && cmd_code == CMD_RX_ENABLE);

endmodule

// file: tb/rfcmd_tx_sink.sv
`timescale 1ns/1ps
module rfcmd_tx_sink #(
	parameter int STALL = 2
) (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic [7:0] tx_byte,
	input  wire logic       tx_byte_valid,
	output logic            tx_byte_ready,
	output int              n_got,
	output logic [7:0]      last_byte
);
	// ****************************************
	// Framer stand-in: slow ready
	// ****************************************
	int wait_cnt;

	// Ready only after STALL waiting cycles, so the link always sees backpressure
	always_ff @(posedge mclk) begin
		if (rst) begin
			wait_cnt      <= 0;
			n_got         <= 0;
			last_byte     <= 8'h00;
			tx_byte_ready <= 1'b0;
		end else if (tx_byte_valid && tx_byte_ready) begin
			n_got         <= n_got + 1;
			last_byte     <= tx_byte;
			wait_cnt      <= 0;
			tx_byte_ready <= 1'b0;
		end else begin
			wait_cnt      <= tx_byte_valid ? wait_cnt + 1 : 0;
			tx_byte_ready <= tx_byte_valid && (wait_cnt >= STALL);
		end
	end
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	import rfcmd_pkg::*;

	// ****************************************
	// Signals
	// ****************************************
	logic       mclk = 1'b0, rst = 1'b1, en_pin = 1'b1, hp_sel = 1'b0, hp_strobe = 1'b0;
	logic [7:0] hp_din = 8'h00, rx_byte = 8'h00, coll_pos = 8'h00, hp_dout, tx_byte, last_byte;
	logic       port_is_serial = 1'b1, osc_stable = 1'b1, rx_byte_valid = 1'b0, coll_valid = 1'b0;
	logic [2:0] rssi_main_code = 3'h0, rssi_aux_code = 3'h0;
	logic       hp_dout_oe, tx_byte_valid, tx_byte_ready, tx_frame_active, tx_append_crc;
	logic       next_slot_pulse, rx_decoder_reset, dummy_clk_active, clk_lo, clk_hi, dly;
	logic [4:0] c;
	logic [7:0] opt_def [10] = '{8'h00, 8'h00, 8'hC1, 8'hC1, 8'h00, 8'h0E, 8'h07, 8'h91, 8'h10, 8'h87};
	logic [4:0] ro_a [4]     = '{5'h0C, 5'h0E, 5'h0F, 5'h1C};
	logic [7:0] ro_v [4]     = '{8'h00, 8'h00, 8'h40, 8'h00};
	int         fail_count = 0, n_compared = 0, dummy_n = 0, slot_n = 0, n0, n_got;

	always #5 mclk = ~mclk;

	rfcmd_core i_dut (.mclk(mclk), .rst(rst), .en_pin(en_pin), .hp_sel(hp_sel), .hp_strobe(hp_strobe),
		.hp_din(hp_din), .hp_dout(hp_dout), .hp_dout_oe(hp_dout_oe), .port_is_serial(port_is_serial),
		.rssi_main_code(rssi_main_code), .rssi_aux_code(rssi_aux_code), .osc_stable(osc_stable),
		.tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid), .tx_byte_ready(tx_byte_ready),
		.tx_frame_active(tx_frame_active), .tx_append_crc(tx_append_crc), .next_slot_pulse(next_slot_pulse),
		.rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid), .coll_valid(coll_valid), .coll_pos(coll_pos),
		.rx_decoder_reset(rx_decoder_reset), .dummy_clk_active(dummy_clk_active),
		.clock_out_div_sel_lo(clk_lo), .clock_out_div_sel_hi(clk_hi));

	rfcmd_tx_sink i_sink (.mclk(mclk), .rst(rst), .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid),
		.tx_byte_ready(tx_byte_ready), .n_got(n_got), .last_byte(last_byte));

	always @(posedge mclk) begin
		if (dummy_clk_active === 1'b1) dummy_n++;
		if (next_slot_pulse === 1'b1) slot_n++;
	end

	// ****************************************
	// Compare and host port tasks
	// ****************************************
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		chk_byte({7'h00, got}, {7'h00, exp});
	endtask

	task automatic chk_int(input int got, input int exp);
		n_compared++;
		if (got != exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// Pin high and low four cycles each, well above the synchroniser minimum
	task automatic put(input logic [7:0] b);
		hp_din <= b;
		cyc(2);
		hp_strobe <= 1'b1;
		cyc(4);
		hp_strobe <= 1'b0;
		cyc(4);
	endtask

	task automatic frame_open;
		hp_sel <= 1'b1;
		cyc(4);
	endtask

	task automatic frame_close;
		hp_sel <= 1'b0;
		cyc(5);
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		frame_open();
		put({3'b000, a});
		put(d);
		frame_close();
	endtask

	task automatic cmd(input logic [4:0] k);
		frame_open();
		put({3'b100, k});
		frame_close();
	endtask

	// Data only counts while the device says it drives the port
	task automatic rd_chk(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
		logic [7:0] d;
		frame_open();
		hp_din <= {3'b010, a};
		cyc(2);
		hp_strobe <= 1'b1;
		cyc(7);
		#1;
		d = (hp_dout_oe === 1'b1) ? hp_dout : 8'hXX;
		chk_byte(d & m, e);
		@(posedge mclk);
		hp_strobe <= 1'b0;
		frame_close();
	endtask

	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		#800000;
		fail_count++;
		final_report();
	end

	initial begin
		cyc(5);
		rst <= 1'b0;
		cyc(5);
		rd_chk(ADDR_CHIP, 8'h01);
		rd_chk(ADDR_PROTO, 8'h02);
		for (int i = 0; i < 10; i++) rd_chk(ADDR_OPT_FIRST + 5'(i), opt_def[i]);
		rd_chk(ADDR_MASK, 8'h3E);
		for (int i = 0; i < 4; i++) begin
			wr(ro_a[i], 8'hFF);
			rd_chk(ro_a[i], ro_v[i]);
		end
		wr(ADDR_SPEC1, 8'hA5);
		rd_chk(ADDR_SPEC1, 8'hA5);
		// Continuous write: address steps once per data byte
		frame_open();
		put({3'b001, ADDR_TEST1});
		put(8'h11);
		put(8'h22);
		frame_close();
		rd_chk(ADDR_TEST1, 8'h11);
		rd_chk(ADDR_TEST2, 8'h22);
		wr(5'h15, 8'h5A);
		rd_chk(5'h15, 8'h00);
		wr(ADDR_RX_WAIT, 8'h33);
		wr(ADDR_MOD_CLK, 8'h21);
		chk_byte({6'h00, clk_hi, clk_lo}, 8'h02);
		rd_chk(ADDR_RX_WAIT, 8'h33);
		wr(ADDR_PROTO, 8'h08);
		wr(ADDR_PROTO, 8'h02);
		rd_chk(ADDR_RX_WAIT, 8'h07);
		rd_chk(ADDR_MOD_CLK, 8'hA1);
		chk_byte({6'h00, clk_hi, clk_lo}, 8'h02);
		dummy_n = 0;
		cmd(CMD_IDLE);
		cyc(10);
		chk_int(dummy_n, 8);
		port_is_serial <= 1'b0;
		cyc(4);
		dummy_n = 0;
		cmd(CMD_IDLE);
		cyc(10);
		chk_int(dummy_n, 1);
		port_is_serial <= 1'b1;
		cmd(CMD_RX_BLOCK);
		chk_bit(rx_decoder_reset, 1'b1);
		cmd(5'h15);
		cmd(5'h1F);
		chk_bit(rx_decoder_reset, 1'b1);
		rd_chk(ADDR_SPEC1, 8'hA5);
		cmd(CMD_RX_ENABLE);
		chk_bit(rx_decoder_reset, 1'b0);
		frame_open();
		put({3'b101, CMD_RX_BLOCK});
		frame_close();
		chk_bit(rx_decoder_reset, 1'b0);
		rssi_main_code <= 3'h5;
		rssi_aux_code <= 3'h2;
		cmd(CMD_RX_ENABLE);
		cmd(CMD_RF_INT);
		rd_chk(ADDR_RSSI, 8'h55);
		rssi_main_code <= 3'h3;
		cmd(CMD_RF_EXT);
		rd_chk(ADDR_RSSI, 8'h43, 8'h47);
		slot_n = 0;
		cmd(CMD_NEXT_SLOT);
		chk_int(slot_n, 1);
		wr(ADDR_PROTO, 8'h08);
		slot_n = 0;
		cmd(CMD_NEXT_SLOT);
		chk_int(slot_n, 0);
		wr(ADDR_PROTO, 8'h02);
		coll_pos <= 8'h2A;
		coll_valid <= 1'b1;
		rx_byte <= 8'h3C;
		rx_byte_valid <= 1'b1;
		cyc(1);
		coll_valid <= 1'b0;
		rx_byte_valid <= 1'b0;
		cyc(2);
		rd_chk(ADDR_COLL, 8'h2A);
		rd_chk(ADDR_FIFO_STAT, 8'h01);
		cmd(CMD_FIFO_RST);
		rd_chk(ADDR_COLL, 8'h00);
		rd_chk(ADDR_FIFO_STAT, 8'h00);
		// Short timer: 5 ticks keeps the delayed cases quick
		wr(ADDR_TMR_HI, 8'h00);
		wr(ADDR_TMR_LO, 8'h05);
		for (int k = 0; k < 4; k++) begin
			c = CMD_TX_NOCRC + 5'(k);
			dly = (k >= 2);
			wr(ADDR_RX_WAIT, (k == 3) ? 8'h01 : 8'h00);
			cmd(CMD_RX_BLOCK);
			cmd(c);
			wr(ADDR_TX_LEN1, 8'h00);
			wr(ADDR_TX_LEN2, 8'h20);
			n0 = n_got;
			wr(ADDR_FIFO_DATA, 8'hC0 + 8'(k));
			chk_bit(tx_frame_active, !dly);
			if (!dly) chk_byte(last_byte, 8'hC0 + 8'(k));
			wr(ADDR_FIFO_DATA, 8'h5A);
			for (int w = 0; w < 2000; w++) begin
				if (n_got - n0 == 2 && tx_frame_active === 1'b0) break;
				cyc(1);
			end
			cyc(2);
			chk_int(n_got - n0, 2);
			chk_byte(last_byte, 8'h5A);
			chk_bit(tx_append_crc, c[0]);
			chk_bit(rx_decoder_reset, k == 3);
		end
		cmd(CMD_RX_ENABLE);
		chk_bit(rx_decoder_reset, 1'b1);
		cyc(880);
		chk_bit(rx_decoder_reset, 1'b1);
		cyc(70);
		chk_bit(rx_decoder_reset, 1'b0);
		wr(ADDR_PROTO, 8'h08);
		cmd(CMD_SW_INIT);
		cmd(CMD_IDLE);
		rd_chk(ADDR_SPEC1, 8'h00);
		rd_chk(ADDR_PROTO, 8'h02);
		rd_chk(ADDR_TMR_LO, 8'hC1);
		chk_byte({6'h00, clk_hi, clk_lo}, 8'h01);
		wr(ADDR_PROTO, 8'h08);
		en_pin <= 1'b0;
		cyc(5);
		en_pin <= 1'b1;
		cyc(5);
		rd_chk(ADDR_PROTO, 8'h02);
		final_report();
	end
endmodule
